// file: common/adc_trig_defs.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef ADC_TRIG_DEFS_SVH
`define ADC_TRIG_DEFS_SVH
`define ADDR_CSR      4'h0
`define ADDR_CR       4'h1
`define ADDR_STOP     4'h2
`define ADDR_IRQ_STAT 4'h3
`define ADDR_IRQ_MASK 4'h4
`define ADDR_RESULT   4'h5
`define CSR_END_FLAG  7
`define CSR_IRQ_EN    6
`define CSR_START     5
`define CSR_SCAN      4
`define CR_TRG_HI     7
`define CR_TRG_LO     6
`define CR_GROUP8     5
`define STOP_RESET    1'b1
`define TRG_EXTERNAL  2'h3
`define CONV_CYCLES   8'h40
`define GROUP4_LAST   3'h3
`define GROUP8_LAST   3'h7
`endif

// file: common/adc_trig_pkg.sv
// Types shared by the converter control block
`default_nettype none
package adc_trig_pkg;
  // Register access request from the CPU side
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
  // Sequencer states, Gray along idle-convert-done
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b11
  } conv_state_t;
endpackage
`default_nettype wire

// file: hdl/adc_trigger_and_end_event.sv
// Converter start, end event and module stop control
//
// Implementation choices: the address-and-strobe port and the register offsets.
`default_nettype none
`include "adc_trig_defs.svh"
module adc_trigger_and_end_event #(
  parameter logic [7:0] CONV_CYCLES = `CONV_CYCLES
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_reset,
  input  wire adc_trig_pkg::reg_req_t i_req,
  input  wire logic                 i_ext_trigger_n,
  output logic [7:0]                o_rdata,
  output logic                      o_conversion_end_request,
  output logic                      o_transfer_activate,
  output logic                      o_irq,
  output logic                      o_converting,
  output logic [2:0]                o_channel
);
  import adc_trig_pkg::*;

  // Control state
  logic        stop_q;          // Module stop
  logic        start_q;         // Conversion start bit
  logic        end_flag_q;      // Conversion end flag
  logic        irq_en_q;        // End interrupt enable
  logic        scan_q;          // Scan mode select
  logic [1:0]  trg_q;           // Trigger source
  logic        group8_q;        // Scan group of eight
  logic        stat_q;          // Sticky event status
  logic        mask_q;          // Event mask
  logic [9:0]  result_q;        // Last result (channel-number stand-in)
  logic [7:0]  cnt_q;           // Conversion cycle counter
  logic [2:0]  chan_q;          // Current channel
  conv_state_t state_q;
  logic        sync1_q, sync2_q, sync3_q;
  logic [7:0]  rdata_q;

  // Decode
  wire wr_csr  = i_req.wr && !stop_q && i_req.addr == `ADDR_CSR;
  wire wr_cr   = i_req.wr && !stop_q && i_req.addr == `ADDR_CR;
  wire wr_stop = i_req.wr && i_req.addr == `ADDR_STOP;
  wire wr_mask = i_req.wr && !stop_q && i_req.addr == `ADDR_IRQ_MASK;
  wire rd_stat = i_req.rd && !stop_q && i_req.addr == `ADDR_IRQ_STAT;
  wire fall    = sync3_q && !sync2_q;
  wire ext_sel = trg_q == `TRG_EXTERNAL;
  wire ext_start = ext_sel && fall && !stop_q;
  wire last_ch = chan_q == (group8_q ? `GROUP8_LAST : `GROUP4_LAST);
  wire conv_end = state_q == ST_CONV && cnt_q == CONV_CYCLES - 8'h01;
  // Group finish raises flag in scan
  wire end_evt = conv_end && (!scan_q || last_ch);
  wire sw_start_set = wr_csr && i_req.wdata[`CSR_START];
  wire sw_start_clr = wr_csr && !i_req.wdata[`CSR_START];

  // Trigger synchroniser
  always_ff @(posedge i_clock) begin
    sync1_q <= i_ext_trigger_n;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  // Module stop, held after reset
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      stop_q <= `STOP_RESET;
    end else if (wr_stop) begin
      stop_q <= i_req.wdata[0];
    end
  end

  // Configuration registers
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq_en_q <= 1'b0;
      scan_q   <= 1'b0;
      trg_q    <= 2'h0;
      group8_q <= 1'b0;
      mask_q   <= 1'b0;
    end else begin
      if (wr_csr) begin
        irq_en_q <= i_req.wdata[`CSR_IRQ_EN];
        scan_q   <= i_req.wdata[`CSR_SCAN];
      end
      if (wr_cr) begin
        trg_q    <= i_req.wdata[`CR_TRG_HI:`CR_TRG_LO];
        group8_q <= i_req.wdata[`CR_GROUP8];
      end
      if (wr_mask) begin
        mask_q <= i_req.wdata[0];
      end
    end
  end

  // Start bit
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      start_q <= 1'b0;
    end else if (sw_start_set || ext_start) begin
      start_q <= 1'b1;
    end else if (sw_start_clr) begin
      start_q <= 1'b0;
    end else if (conv_end && !scan_q) begin
      start_q <= 1'b0;
    end
  end

  // Sequencer
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q  <= ST_WAIT;
      cnt_q    <= 8'h00;
      chan_q   <= 3'h0;
      result_q <= 10'h000;
    end else begin
      unique case (state_q)
        ST_WAIT: begin
          cnt_q  <= 8'h00;
          chan_q <= 3'h0;
          if (start_q) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (!start_q) begin
            state_q <= ST_WAIT;
          end else if (conv_end) begin
            result_q <= {7'h00, chan_q};
            cnt_q    <= 8'h00;
            if (!scan_q) begin
              state_q <= ST_DONE;
            end else begin
              chan_q <= last_ch ? 3'h0 : chan_q + 3'h1;
            end
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_DONE: begin
          state_q <= ST_WAIT;
        end
        // Unused code falls back to wait
        default: begin
          state_q <= ST_WAIT;
        end
      endcase
    end
  end

  // End flag and sticky status; set wins over clear
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      end_flag_q <= 1'b0;
      stat_q     <= 1'b0;
    end else begin
      if (end_evt) begin
        end_flag_q <= 1'b1;
      end else if (wr_csr && !i_req.wdata[`CSR_END_FLAG]) begin
        end_flag_q <= 1'b0;
      end
      if (end_evt) begin
        stat_q <= 1'b1;
      end else if (rd_stat) begin
        stat_q <= 1'b0;
      end
    end
  end

  // Read mux and registered outputs
  wire [7:0] rmux =
    stop_q && i_req.addr != `ADDR_STOP ? 8'h00 :
    i_req.addr == `ADDR_CSR  ? {end_flag_q, irq_en_q, start_q, scan_q, 4'h0} :
    i_req.addr == `ADDR_CR   ? {trg_q, group8_q, 5'h00} :
    i_req.addr == `ADDR_STOP ? {7'h00, stop_q} :
    i_req.addr == `ADDR_IRQ_STAT ? {7'h00, stat_q} :
    i_req.addr == `ADDR_IRQ_MASK ? {7'h00, mask_q} :
    i_req.addr == `ADDR_RESULT ? result_q[7:0] : 8'h00;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rdata_q                  <= 8'h00;
      o_conversion_end_request <= 1'b0;
      o_transfer_activate      <= 1'b0;
      o_irq                    <= 1'b0;
      o_converting             <= 1'b0;
      o_channel                <= 3'h0;
    end else begin
      rdata_q <= i_req.rd ? rmux : 8'h00;
      // Request only while enabled and set
      o_conversion_end_request <= irq_en_q && end_flag_q;
      o_transfer_activate      <= irq_en_q && end_evt;
      o_irq                    <= stat_q && mask_q;
      o_converting             <= state_q == ST_CONV;
      o_channel                <= chan_q;
    end
  end
  assign o_rdata = rdata_q;

  // Single mode returns start to zero
  a_single_clear: assert property (
    @(posedge i_clock) disable iff (i_reset)
    conv_end && !scan_q && !sw_start_set && !ext_start |=> !start_q)
    else $error("start bit not cleared after single conversion");
  a_scan_hold: assert property (
    @(posedge i_clock) disable iff (i_reset)
    conv_end && scan_q && !sw_start_clr |=> start_q)
    else $error("start bit dropped in scan mode");
  a_req_gate: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_conversion_end_request |-> $past(irq_en_q && end_flag_q))
    else $error("end request without enable and flag");
  a_abort_wait: assert property (
    @(posedge i_clock) disable iff (i_reset)
    state_q == ST_CONV && !start_q |=> state_q == ST_WAIT)
    else $error("abort did not reach wait");
  a_edge_start: assert property (
    @(posedge i_clock) disable iff (i_reset)
    ext_start |=> start_q)
    else $error("external edge did not set start");
  a_src_gate: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !ext_sel && !sw_start_set && !start_q |=> !start_q)
    else $error("start without selected source");
  a_stop_lock: assert property (
    @(posedge i_clock) disable iff (i_reset)
    stop_q && !wr_stop |=> $stable(trg_q) && $stable(irq_en_q))
    else $error("register written in module stop");
  a_one_start: assert property (
    @(posedge i_clock) disable iff (i_reset)
    fall |=> !fall)
    else $error("double edge from one fall");
endmodule
`default_nettype wire

// file: tb/adc_trigger_and_end_event_tb.sv
// Self-checking bench for converter start and end event
`default_nettype none
module adc_trigger_and_end_event_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_trig_pkg::*;
  logic       clock = 1'b0;  // Core clock
  logic       reset = 1'b1;  // Sync reset
  logic       trig_n = 1'b1; // Trigger pin
  reg_req_t   req = '0;      // Register request
  logic [7:0] rdata;
  logic       end_req, act, irq, conv;
  logic [2:0] chan;
  logic [7:0] v;             // Last read value
  int         acts, failures = 0, tests_run = 0;
  // 250 MHz clock
  always #2 clock = ~clock;
  adc_trigger_and_end_event #(.CONV_CYCLES(8'h10)) dut (
    .i_clock(clock), .i_reset(reset), .i_req(req),
    .i_ext_trigger_n(trig_n), .o_rdata(rdata),
    .o_conversion_end_request(end_req), .o_transfer_activate(act),
    .o_irq(irq), .o_converting(conv), .o_channel(chan));
  end_event_sink sink (
    .i_clock(clock), .i_reset(reset), .i_activate(act), .o_count(acts));
  // Verdict and end of run
  task wrap_up;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
    end
  endtask
  // One-cycle write strobe
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  // Read; data taken in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clock);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Bounded wait: 0 for converting, 1 for end request
  task wt(input int s);
    for (int i = 0; i < 200; i++) begin
      @(posedge clock);
      #1;
      if ((s == 0 && conv === 1'b1) || (s == 1 && end_req === 1'b1)) return;
    end
    failures++;
    wrap_up();
  endtask
  task t_stop;
    rd(4'h2);
    chk("stop_rst", v, 8'h01);
    wr(4'h0, 8'h40);
    rd(4'h0);
    chk("csr_in_stop", v, 8'h00);
    wr(4'h2, 8'h00);
    rd(4'h0);
    chk("csr_locked", v, 8'h00);
    rd(4'hF);
    chk("unmapped", v, 8'h00);
  endtask
  task t_ext;
    wr(4'h1, 8'hC0);
    wr(4'h0, 8'h40);
    wr(4'h4, 8'h01);
    @(posedge clock) trig_n <= 1'b0;
    wt(0);
    wt(1);
    chk("irq_set", irq, 1'b1);
    rd(4'h0);
    chk("csr_end", v, 8'hC0);
    rd(4'h3);
    chk("stat", v, 8'h01);
    rd(4'h3);
    chk("stat_clr", v, 8'h00);
    repeat (2) @(posedge clock);
    #1 chk("irq_clr", irq, 1'b0);
    chk("one_start", conv, 1'b0);
    chk("acts_ext", 8'(acts), 8'h01);
  endtask
  task t_standby;
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h00);
    @(posedge clock) trig_n <= 1'b1;
    repeat (3) @(posedge clock);
    trig_n <= 1'b0;
    repeat (12) begin
      @(posedge clock);
      #1 chk("no_ext", conv, 1'b0);
    end
    chk("end_drop", end_req, 1'b0);
  endtask
  task t_abort;
    wr(4'h0, 8'h60);
    wt(0);
    wr(4'h0, 8'h40);
    repeat (2) @(posedge clock);
    #1 chk("abort", conv, 1'b0);
    repeat (24) @(posedge clock);
    #1 chk("abort_end", end_req, 1'b0);
    chk("acts_abort", 8'(acts), 8'h01);
  endtask
  task t_scan;
    wr(4'h0, 8'h70);
    wt(1);
    rd(4'h0);
    chk("scan_csr", v, 8'hF0);
    chk("scan_chan", chan, 3'h0);
    chk("scan_conv", conv, 1'b1);
    rd(4'h5);
    chk("scan_result", v, 8'h03);
    wr(4'h0, 8'h00);
    chk("acts_scan", 8'(acts), 8'h02);
    // Group of eight channels
    wr(4'h1, 8'h20);
    wr(4'h0, 8'h70);
    wt(1);
    rd(4'h5);
    chk("scan8_last", v, 8'h07);
    wr(4'h0, 8'h00);
    chk("acts_scan8", 8'(acts), 8'h03);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    t_stop();
    t_ext();
    t_standby();
    t_abort();
    t_scan();
    wrap_up();
  end
endmodule
`default_nettype wire

// file: tb/end_event_sink.sv
// Far-side transfer controller model counting activations
`default_nettype none
module end_event_sink (
  input  wire logic i_clock,
  input  wire logic i_reset,
  input  wire logic i_activate,
  output int        o_count
);
  timeunit 1ns;
  timeprecision 100ps;
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_count <= 0;
    end else if (i_activate) begin
      o_count <= o_count + 1;
    end
  end
endmodule
`default_nettype wire
